// [spfdr_arm.sv]
// One flag with its clearing record: set from hardware, armed by a status read.
// Assumes single clock; set wins over clear in the same cycle.
`timescale 1ns/1ps
module spfdr_arm (
	input  wire logic CLK,
	input  wire logic SYS_RST,
	input  wire logic set_ev,    // Hardware event sets flag
	input  wire logic rst_val,   // Reset value of flag
	input  wire logic stat_rd,   // Status register read
	input  wire logic clr_acc,   // Qualifying data access by CPU
	input  wire logic dma_clr,   // Direct clear by DMA access
	output logic      flag_r     // Flag state
);
	import spfdr_pkg::*;
	logic             armed_r;   // Status read observed the flag set
	logic             cpu_clr;   // CPU sequence completes
	logic             flag_nxt;
	logic             armed_nxt;
	assign cpu_clr   = clr_acc & armed_r;
	assign flag_nxt  = set_ev | (flag_r & ~cpu_clr & ~dma_clr);  // Set wins
	// Record follows the status read only; a set landing with the clearing
	// access must not leave a stale record that clears the new event later
	assign armed_nxt = stat_rd ? flag_r : (armed_r & ~clr_acc & ~dma_clr);
	// Reset value is a tie-off, never a live pin; caught after release instead
	logic init_r;
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			flag_r  <= 1'b0;
			armed_r <= 1'b0;
			init_r  <= 1'b1;
		end else begin
			init_r  <= 1'b0;
			flag_r  <= init_r ? (rst_val | set_ev) : flag_nxt;
			armed_r <= init_r ? 1'b0 : armed_nxt;
		end
	end
endmodule

// [spfdr_dma_model.sv]
// DMA controller stand-in serving receive and transmit requests.
// Assumes requests drop one edge after the serving strobe.
`timescale 1ns/1ps
module spfdr_dma_model (
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	input  wire logic [3:0] lat,       // Answer delay in cycles
	input  wire logic       tx_req,    // Transmit service request
	input  wire logic       rx_req,    // Receive service request
	output logic            dma_wr,    // One-cycle write strobe
	output logic [7:0]      dma_wdata, // Byte written
	output logic            dma_rd     // One-cycle read strobe
);
	logic [3:0] tx_cnt_r; // Wait count, transmit
	logic [3:0] rx_cnt_r; // Wait count, receive
	// Write; skip strobe cycle since the request falls one edge late
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_cnt_r  <= 4'h0;
			dma_wr    <= 1'b0;
			dma_wdata <= 8'h00;
		end else if (tx_req && !dma_wr && tx_cnt_r == lat) begin
			tx_cnt_r  <= 4'h0;
			dma_wr    <= 1'b1;
			dma_wdata <= 8'($urandom);
		end else begin
			// Data not held outside the strobe
			tx_cnt_r  <= (tx_req && !dma_wr) ? tx_cnt_r + 4'h1 : 4'h0;
			dma_wr    <= 1'b0;
			dma_wdata <= ~dma_wdata;
		end
	end
	// Read once the wait runs out
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_cnt_r <= 4'h0;
			dma_rd   <= 1'b0;
		end else begin
			dma_rd   <= rx_req && !dma_rd && rx_cnt_r == lat;
			rx_cnt_r <= (rx_req && !dma_rd && rx_cnt_r != lat) ? rx_cnt_r + 4'h1 : 4'h0;
		end
	end
endmodule

// [spfdr_pkg.sv]
// Package for the serial port flag and DMA request block.
// Assumes an APB slave with 32-bit data; registers sit in the low byte of each word.
// Summary of operation
// - Nine-bit mode: received ninth bit captured with data
// - Eight-bit mode: ninth field mirrors bit 7
// - Transmit ninth bit loads with data, reset-immune
// - Receive DMA enable suppresses receiver CPU requests
// - Receiver full: CPU or DMA request by enables
// - Transmit DMA enable suppresses empty CPU request
// - Transmitter empty: CPU or DMA request
// - Overrun enable gates error request
// - Noise enable gates error request
// - Framing enable gates error request
// - Parity enable gates error request
// - Empty flag sets on handoff, reset sets
// - CPU clears empty: status read then write
// - DMA data write clears empty directly
// - First transmitter enable sets empty flag
// - Done flag: empty and idle, reset sets
// - Done flag requests CPU when enabled
// - Done flag clears when anything queued
// - Full flag sets on receive transfer, reset clears
// - Full clears: status read then data read
// - Receive DMA blocks all receiver CPU requests
package spfdr_pkg;
	// Register byte addresses
	localparam logic [7:0] SPFDR_ADDR_DATA   = 8'h00;
	localparam logic [7:0] SPFDR_ADDR_CTRL2  = 8'h04;
	localparam logic [7:0] SPFDR_ADDR_CTRL3  = 8'h08;
	localparam logic [7:0] SPFDR_ADDR_STAT1  = 8'h0C;
	// Control two bit positions
	localparam int SPFDR_C2_TX_EMPTY_IE = 7;
	localparam int SPFDR_C2_TX_DONE_IE  = 6;
	localparam int SPFDR_C2_RX_FULL_IE  = 5;
	localparam int SPFDR_C2_IDLE_IE     = 4;
	localparam int SPFDR_C2_TX_EN       = 3;
	// Control three bit positions
	localparam int SPFDR_C3_RX_NINTH    = 7;
	localparam int SPFDR_C3_TX_NINTH    = 6;
	localparam int SPFDR_C3_RX_DMA      = 5;
	localparam int SPFDR_C3_TX_DMA      = 4;
	localparam int SPFDR_C3_OVR_IE      = 3;
	localparam int SPFDR_C3_NOISE_IE    = 2;
	localparam int SPFDR_C3_FRAME_IE    = 1;
	localparam int SPFDR_C3_PARITY_IE   = 0;
	// Status one bit positions
	localparam int SPFDR_S1_TX_EMPTY    = 7;
	localparam int SPFDR_S1_TX_DONE     = 6;
	localparam int SPFDR_S1_RX_FULL     = 5;
	localparam int SPFDR_S1_IDLE        = 4;
	localparam int SPFDR_S1_OVERRUN     = 3;
	localparam int SPFDR_S1_NOISE       = 2;
	localparam int SPFDR_S1_FRAMING     = 1;
	localparam int SPFDR_S1_PARITY      = 0;
	// Number of receiver error and idle flags
	localparam int SPFDR_NUM_RX_FLAGS   = 5;
	// Reset values
	localparam logic [7:0] SPFDR_CTRL_RST = 8'h00;
	localparam logic [31:0] SPFDR_ZERO32  = 32'h0000_0000;
	// Clearing-sequence states of the CPU status reader
	typedef enum logic [1:0] {SPFDR_SEQ_IDLE, SPFDR_SEQ_ARMED, SPFDR_SEQ_SPARE} spfdr_seq_type;
endpackage

// [spfdr_top.sv]
// Flag and request routing of an asynchronous serial port, APB slave.
// Assumes shifter and detectors sit outside and give one-cycle event pulses.
// Register map: data at 0x00, control two 0x04, control three 0x08, status one 0x0C.
`timescale 1ns/1ps
module spfdr_top (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// DMA data port, one-cycle strobes
	input  wire logic        DMA_WR,
	input  wire logic [7:0]  DMA_WDATA,
	input  wire logic        DMA_RD,
	output logic [7:0]       DMA_RDATA,
	// Character format from the shifter side
	input  wire logic        NINE_BIT_MODE,
	// Receive shifter events
	input  wire logic        RX_LOAD,
	input  wire logic [8:0]  RX_CHAR,
	input  wire logic        IDLE_EV,
	input  wire logic        OVERRUN_EV,
	input  wire logic        NOISE_EV,
	input  wire logic        FRAMING_EV,
	input  wire logic        PARITY_EV,
	// Transmit shifter handshake
	input  wire logic        TX_TAKE,
	input  wire logic        TX_ACTIVE,
	output logic [8:0]       TX_CHAR,
	output logic             TX_QUEUED,
	// Requests
	output logic             RX_IRQ,
	output logic             TX_IRQ,
	output logic             ERR_IRQ,
	output logic             RX_DMA_REQ,
	output logic             TX_DMA_REQ
);
	import spfdr_pkg::*;

	// Control and data storage
	logic [7:0] ctrl2_r;          // Interrupt enables and transmitter enable
	logic [5:0] ctrl3_r;          // DMA enables and error enables
	logic       tx_ninth_bit_r;   // Written ninth bit, reset-immune
	logic       rx_ninth_bit_r;   // Received ninth bit, reset-immune
	logic [7:0] rx_data_r;        // Received byte
	logic [7:0] tx_data_r;        // Byte waiting for the shifter
	logic       tx_pend_r;        // Data or preamble queued
	logic       tx_en_seen_r;     // Transmitter has been enabled once
	logic       tx_done_r;        // Transmission complete flag
	logic [31:0] prdata_r;        // Registered read data

	// Access decode
	wire acc      = PSEL & PENABLE;
	wire wr_acc   = acc & PWRITE;
	wire rd_acc   = acc & ~PWRITE;
	wire hit_data = (PADDR == SPFDR_ADDR_DATA);
	wire hit_c2   = (PADDR == SPFDR_ADDR_CTRL2);
	wire hit_c3   = (PADDR == SPFDR_ADDR_CTRL3);
	wire hit_s1   = (PADDR == SPFDR_ADDR_STAT1);
	wire mapped   = hit_data | hit_c2 | hit_c3 | hit_s1;
	wire cpu_dwr  = wr_acc & hit_data;
	wire cpu_drd  = rd_acc & hit_data;
	wire stat_rd  = rd_acc & hit_s1;
	wire c2_wr    = wr_acc & hit_c2;
	wire c3_wr    = wr_acc & hit_c3;

	// Named control bits
	wire tx_empty_irq_enable = ctrl2_r[SPFDR_C2_TX_EMPTY_IE];
	wire tx_done_irq_enable  = ctrl2_r[SPFDR_C2_TX_DONE_IE];
	wire rx_full_irq_enable  = ctrl2_r[SPFDR_C2_RX_FULL_IE];
	wire idle_irq_enable     = ctrl2_r[SPFDR_C2_IDLE_IE];
	wire tx_enable           = ctrl2_r[SPFDR_C2_TX_EN];
	wire rx_dma_enable       = ctrl3_r[SPFDR_C3_RX_DMA];
	wire tx_dma_enable       = ctrl3_r[SPFDR_C3_TX_DMA];
	wire overrun_irq_enable  = ctrl3_r[SPFDR_C3_OVR_IE];
	wire noise_irq_enable    = ctrl3_r[SPFDR_C3_NOISE_IE];
	wire framing_irq_enable  = ctrl3_r[SPFDR_C3_FRAME_IE];
	wire parity_irq_enable   = ctrl3_r[SPFDR_C3_PARITY_IE];

	// First rising of the transmitter enable queues a preamble
	wire tx_en_first = c2_wr & PWDATA[SPFDR_C2_TX_EN] & ~tx_en_seen_r;
	// Shifter takes data or preamble; hands off empties the data buffer
	wire tx_handoff  = TX_TAKE & tx_pend_r;
	// Anything written to the data register is queued
	wire data_wr     = cpu_dwr | DMA_WR;

	// Transmitter empty flag
	logic tx_empty_flag;
	spfdr_arm u_tx_empty (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.set_ev  (tx_handoff | tx_en_first),
		.rst_val (1'b1),
		.stat_rd (stat_rd),
		.clr_acc (cpu_dwr),
		.dma_clr (DMA_WR),
		.flag_r  (tx_empty_flag)
	);

	// Receiver full flag
	logic rx_full_flag;
	spfdr_arm u_rx_full (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.set_ev  (RX_LOAD),
		.rst_val (1'b0),
		.stat_rd (stat_rd),
		.clr_acc (cpu_drd),
		.dma_clr (DMA_RD),
		.flag_r  (rx_full_flag)
	);

	// Receiver idle and error flags, cleared by status read then data read
	logic [SPFDR_NUM_RX_FLAGS-1:0] rx_ev;
	logic [SPFDR_NUM_RX_FLAGS-1:0] rx_flags;
	assign rx_ev = {IDLE_EV, OVERRUN_EV, NOISE_EV, FRAMING_EV, PARITY_EV};
	genvar gi;
	generate
		for (gi = 0; gi < SPFDR_NUM_RX_FLAGS; gi++) begin : g_rxf
			spfdr_arm u_f (
				.CLK     (CLK),
				.SYS_RST (SYS_RST),
				.set_ev  (rx_ev[gi]),
				.rst_val (1'b0),
				.stat_rd (stat_rd),
				.clr_acc (cpu_drd),
				.dma_clr (1'b0),
				.flag_r  (rx_flags[gi])
			);
		end
	endgenerate
	wire idle_flag         = rx_flags[SPFDR_S1_IDLE];
	wire overrun_flag      = rx_flags[SPFDR_S1_OVERRUN];
	wire noise_flag        = rx_flags[SPFDR_S1_NOISE];
	wire framing_fault_flag = rx_flags[SPFDR_S1_FRAMING];
	wire parity_fault_flag = rx_flags[SPFDR_S1_PARITY];

	// Status image
	wire [7:0] stat1 = {tx_empty_flag, tx_done_r, rx_full_flag, rx_flags};
	wire [7:0] ctrl3_img = {rx_ninth_bit_r, tx_ninth_bit_r, ctrl3_r};

	// Control registers, cleared by reset
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl2_r <= SPFDR_CTRL_RST;
			ctrl3_r <= SPFDR_CTRL_RST[5:0];
		end else begin
			if (c2_wr) begin
				ctrl2_r <= PWDATA[7:0];
			end
			if (c3_wr) begin
				ctrl3_r <= PWDATA[5:0];
			end
		end
	end

	// Reset-immune data path: ninth bits and data bytes
	always_ff @(posedge CLK) begin
		if (c3_wr) begin
			tx_ninth_bit_r <= PWDATA[SPFDR_C3_TX_NINTH];
		end
		if (RX_LOAD) begin
			rx_data_r      <= RX_CHAR[7:0];
			// Ninth bit or copy of bit 7, caught with the byte
			rx_ninth_bit_r <= NINE_BIT_MODE ? RX_CHAR[8] : RX_CHAR[7];
		end
		if (DMA_WR) begin
			tx_data_r <= DMA_WDATA;
		end else if (cpu_dwr) begin
			tx_data_r <= PWDATA[7:0];
		end
		if (tx_handoff) begin
			TX_CHAR <= {tx_ninth_bit_r, tx_data_r};
		end
	end

	// Transmit queue state and completion flag
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_pend_r    <= 1'b0;
			tx_en_seen_r <= 1'b0;
			tx_done_r    <= 1'b1;
		end else begin
			tx_pend_r <= (data_wr | tx_en_first) | (tx_pend_r & ~TX_TAKE);
			if (tx_en_first) begin
				tx_en_seen_r <= 1'b1;
			end
			if (data_wr | tx_en_first) begin
				tx_done_r <= 1'b0;
			end else if (tx_empty_flag & ~tx_pend_r & ~TX_ACTIVE) begin
				tx_done_r <= 1'b1;
			end
		end
	end
	assign TX_QUEUED = tx_pend_r;

	// Request routing
	assign RX_IRQ     = ~rx_dma_enable & ((rx_full_flag & rx_full_irq_enable)
		| (idle_flag & idle_irq_enable));
	assign RX_DMA_REQ = rx_dma_enable & rx_full_irq_enable & rx_full_flag;
	assign TX_IRQ     = (tx_empty_flag & tx_empty_irq_enable & ~tx_dma_enable)
		| (tx_done_r & tx_done_irq_enable);
	assign TX_DMA_REQ = tx_dma_enable & tx_empty_irq_enable & tx_empty_flag;
	// Error requests also fall silent under receive DMA
	assign ERR_IRQ    = ~rx_dma_enable & ((overrun_flag & overrun_irq_enable)
		| (noise_flag & noise_irq_enable)
		| (framing_fault_flag & framing_irq_enable)
		| (parity_fault_flag & parity_irq_enable));

	// APB read mux; zero wait states
	wire [31:0] rd_mux = hit_data ? {24'h00_0000, rx_data_r} :
		hit_c2 ? {24'h00_0000, ctrl2_r} :
		hit_c3 ? {24'h00_0000, ctrl3_img} :
		hit_s1 ? {24'h00_0000, stat1} : SPFDR_ZERO32;
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			prdata_r <= SPFDR_ZERO32;
		end else if (PSEL & ~PENABLE & ~PWRITE) begin
			prdata_r <= rd_mux;
		end
	end
	assign PRDATA    = prdata_r;
	assign PREADY    = 1'b1;
	assign PSLVERR   = acc & ~mapped;
	assign DMA_RDATA = rx_data_r;
endmodule

// [spfdr_top_sva.sv]
// Checker: request and flag relations at the top ports.
// Assumes a bind onto spfdr_top and a single clock domain.
`timescale 1ns/1ps
module spfdr_top_sva (
	input wire logic       CLK,
	input wire logic       SYS_RST,
	input wire logic       PSEL,
	input wire logic       PENABLE,
	input wire logic       PWRITE,
	input wire logic       DMA_WR,
	input wire logic       DMA_RD,
	input wire logic [7:0] DMA_RDATA,
	input wire logic       RX_LOAD,
	input wire logic [8:0] RX_CHAR,
	input wire logic       IDLE_EV,
	input wire logic       OVERRUN_EV,
	input wire logic       NOISE_EV,
	input wire logic       FRAMING_EV,
	input wire logic       PARITY_EV,
	input wire logic       TX_TAKE,
	input wire logic       TX_QUEUED,
	input wire logic       RX_IRQ,
	input wire logic       ERR_IRQ,
	input wire logic       RX_DMA_REQ,
	input wire logic       TX_DMA_REQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Completed register write: may change any enable
	wire       apb_wr  = PSEL && PENABLE && PWRITE;
	wire [7:0] rx_low  = RX_CHAR[7:0];
	// Legal causes for a request to rise
	wire       err_why = IDLE_EV || OVERRUN_EV || NOISE_EV || FRAMING_EV || PARITY_EV || apb_wr;
	wire       rx_why  = RX_LOAD || apb_wr;
	wire       tx_why  = TX_TAKE || apb_wr;
	AST_RX_EXCL: assert property (!(RX_IRQ && RX_DMA_REQ))
		else $error("receive cpu and dma request together");
	AST_RX_BYTE: assert property (RX_LOAD |=> DMA_RDATA == $past(rx_low))
		else $error("received byte not captured");
	AST_TX_QUEUE: assert property (DMA_WR && !TX_TAKE |=> TX_QUEUED)
		else $error("dma write not queued");
	AST_TX_DMACLR: assert property (DMA_WR && !TX_TAKE && !apb_wr |=> !TX_DMA_REQ)
		else $error("dma write left empty set");
	AST_RX_DMACLR: assert property (DMA_RD && !RX_LOAD |=> !RX_DMA_REQ)
		else $error("dma read left full set");
	AST_ERR_CAUSE: assert property ($rose(ERR_IRQ) |-> $past(err_why))
		else $error("error request without cause");
	AST_RX_CAUSE: assert property ($rose(RX_DMA_REQ) |-> $past(rx_why))
		else $error("receive dma request without cause");
	AST_TX_CAUSE: assert property ($rose(TX_DMA_REQ) |-> $past(tx_why))
		else $error("transmit dma request without cause");
endmodule
bind spfdr_top spfdr_top_sva u_spfdr_top_sva (.*);

// [test_serial_port_flag_dma_request.sv]
// Testbench: APB master, shifter stubs, DMA model, queued expectations.
// Assumes spfdr_pkg, spfdr_top, the checker and the DMA model compiled first.
`timescale 1ns/1ps
module test_serial_port_flag_dma_request;
	import spfdr_pkg::*;
	logic        clk, rst, psel, penable, pwrite, rx_load, tx_take, tx_active, nine, tx9, err;
	logic        dma_wr, dma_rd, pready, pslverr, tx_queued, rx_irq, tx_irq, err_irq, rx_req, tx_req;
	logic [7:0]  paddr, dma_wdata, dma_rdata;
	logic [31:0] pwdata, prdata, r;
	logic [8:0]  rx_char, tx_char, c;
	logic [4:0]  ev;      // Idle, overrun, noise, framing, parity
	logic [3:0]  lat;     // DMA answer delay
	logic [7:0]  txq[$];  // Expected transmit bytes
	int          n_errors, n_compared, i;
	spfdr_top u_spfdr_top (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .DMA_WR(dma_wr), .DMA_WDATA(dma_wdata), .DMA_RD(dma_rd),
		.DMA_RDATA(dma_rdata), .NINE_BIT_MODE(nine), .RX_LOAD(rx_load), .RX_CHAR(rx_char),
		.IDLE_EV(ev[4]), .OVERRUN_EV(ev[3]), .NOISE_EV(ev[2]), .FRAMING_EV(ev[1]),
		.PARITY_EV(ev[0]), .TX_TAKE(tx_take), .TX_ACTIVE(tx_active), .TX_CHAR(tx_char),
		.TX_QUEUED(tx_queued), .RX_IRQ(rx_irq), .TX_IRQ(tx_irq), .ERR_IRQ(err_irq),
		.RX_DMA_REQ(rx_req), .TX_DMA_REQ(tx_req));
	spfdr_dma_model u_spfdr_dma_model (.CLK(clk), .SYS_RST(rst), .lat(lat), .tx_req(tx_req),
		.rx_req(rx_req), .dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_rd(dma_rd));
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// APB transfer held until pready; data writes queue a byte
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		if (wr && a == SPFDR_ADDR_DATA) txq.push_back(d[7:0]);
		if (wr && a == SPFDR_ADDR_CTRL3) tx9 = d[6];
	endtask
	// One-cycle event pulse, then let flags settle
	task automatic pulse(input logic [4:0] e, input logic ld);
		@(posedge clk);
		{ev, rx_load, rx_char} <= {e, ld, c};
		@(posedge clk);
		{ev, rx_load} <= 6'h00;
		#1;
	endtask
	// Shifter takes one character; ninth bit is the one at take time
	task automatic take(input logic cmp);
		repeat (50) if (tx_queued !== 1'b1) @(posedge clk);
		tx_take <= 1'b1;
		@(posedge clk);
		tx_take <= 1'b0;
		#1;
		if (cmp) chk("tx_char", 32'({tx9, txq.pop_front()}), 32'(tx_char));
	endtask
	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Snoop DMA writes into the expected queue
	always @(posedge clk) if (dma_wr === 1'b1) txq.push_back(dma_wdata);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Watchdog against hangs
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude();
	end
	initial begin
		void'($urandom(55));
		{psel, penable, pwrite, rx_load, tx_take, tx_active, nine, tx9, ev, lat} = '0;
		{paddr, pwdata, rx_char, c, n_errors, n_compared} = '0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(0, SPFDR_ADDR_STAT1, 0);
		chk("stat1", 32'h0000_00C0, r);
		apb(0, SPFDR_ADDR_CTRL3, 0);
		chk("ctrl3", 0, r & 32'h0000_003F);
		apb(0, 8'h10, 0);
		chk("unmapped", 1, {r[30:0], err});
		// CPU receive, eight then nine bits
		apb(1, SPFDR_ADDR_CTRL2, 32'h0000_0020);
		for (int m = 0; m < 2; m++) begin
			nine <= m[0];
			c = 9'($urandom);
			pulse(5'h00, 1'b1);
			chk("rx_irq", 1, rx_irq);
			apb(0, SPFDR_ADDR_DATA, 0);
			#1;
			chk("rx_data", c[7:0], r);
			chk("rx_irq", 1, rx_irq);
			apb(0, SPFDR_ADDR_CTRL3, 0);
			chk("rx_ninth", m ? c[8] : c[7], r[7]);
			apb(0, SPFDR_ADDR_STAT1, 0);
			apb(0, SPFDR_ADDR_DATA, 0);
			#1;
			chk("rx_irq", 0, rx_irq);
		end
		// Each error enable gates only its own flag
		for (i = 0; i < 4; i++) begin
			apb(1, SPFDR_ADDR_CTRL3, 32'(1 << i));
			pulse(5'(1 << ((i + 1) % 4)), 1'b0);
			chk("err_irq", 0, err_irq);
			pulse(5'(1 << i), 1'b0);
			chk("err_irq", 1, err_irq);
			apb(0, SPFDR_ADDR_STAT1, 0);
			apb(0, SPFDR_ADDR_DATA, 0);
			#1;
			chk("err_irq", 0, err_irq);
		end
		// Receive by DMA with growing delay; no CPU data reads meanwhile
		apb(1, SPFDR_ADDR_CTRL2, 32'h0000_0030);
		apb(1, SPFDR_ADDR_CTRL3, 32'h0000_0020);
		for (i = 0; i < 4; i++) begin
			c = 9'($urandom);
			pulse(5'h10, 1'b1);
			chk("dma_rdata", c[7:0], dma_rdata);
			chk("rx_req", 1, rx_req);
			chk("rx_irq", 0, rx_irq);
			repeat (20) if (rx_req === 1'b1) @(posedge clk);
			lat <= 4'(i);
		end
		// Idle request comes back once receive DMA is off
		apb(1, SPFDR_ADDR_CTRL3, 32'h0000_0000);
		#1;
		chk("rx_irq", 1, rx_irq);
		// Clear empty before the first enable, which must set it again
		apb(0, SPFDR_ADDR_STAT1, 0);
		apb(1, SPFDR_ADDR_DATA, $urandom);
		apb(0, SPFDR_ADDR_STAT1, 0);
		chk("tx_empty", 0, r[7]);
		// Transmit: CPU byte first, then DMA characters
		apb(1, SPFDR_ADDR_CTRL2, 32'h0000_0008);
		apb(0, SPFDR_ADDR_STAT1, 0);
		chk("tx_empty", 1, r[7]);
		apb(1, SPFDR_ADDR_CTRL3, 32'h0000_0040);
		take(1'b1);
		apb(1, SPFDR_ADDR_CTRL3, 32'h0000_0050);
		apb(1, SPFDR_ADDR_CTRL2, 32'h0000_0088);
		#1;
		chk("tx_irq", 0, tx_irq);
		chk("tx_req", 1, tx_req);
		for (i = 0; i < 4; i++) take(1'b1);
		apb(1, SPFDR_ADDR_CTRL2, 32'h0000_0048);
		apb(1, SPFDR_ADDR_CTRL3, 32'h0000_0000);
		if (txq.size() > 0) take(1'b1);
		// CPU data write only once transmit DMA is off
		tx_active <= 1'b1;
		apb(0, SPFDR_ADDR_STAT1, 0);
		apb(1, SPFDR_ADDR_DATA, $urandom);
		apb(0, SPFDR_ADDR_STAT1, 0);
		chk("empty_done", 0, r[7:6]);
		take(1'b1);
		chk("tx_irq", 0, tx_irq);
		@(posedge clk);
		tx_active <= 1'b0;
		@(posedge clk);
		#1;
		chk("tx_irq", 1, tx_irq);
		conclude();
	end
endmodule
